// File: design/srtap_top.sv
// RAM-tapped shift register: buffered input, a chain of tap segments,
// a concatenated tap bus, optional per-tap groups and a chain-end word.
// Assumes all control inputs come from logic on clk_sys.
`timescale 1ns/10ps
module srtap_top
    import srtap_pkg::*;
#(
    parameter int WORD_W     = WORD_W_DEF,
    parameter int TAP_COUNT  = TAPS_DEF,
    parameter int SPACING    = SPACING_DEF,
    parameter bit USE_CLKEN  = 1'b0,
    parameter bit USE_ACLR   = 1'b0,
    parameter bit GROUP_TAPS = 1'b0,
    parameter int BUF_DEPTH  = FIFO_DEPTH
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          clk_en = 1'b1,
    input  wire logic                          aclr = 1'b0,
    input  wire logic                          in_valid,
    input  wire logic [WORD_W-1:0]             shift_in,
    output logic                               in_ready,
    output logic [WORD_W*TAP_COUNT-1:0]        tap_bus,
    output logic [TAP_COUNT-1:0][WORD_W-1:0]   tap_group,
    output logic [WORD_W-1:0]                  shift_out,
    output logic                               chain_primed
);
    localparam int CHAIN_LEN = TAP_COUNT * SPACING;

    // Reject illegal builds at elaboration
    if (WORD_W < WORD_W_MIN || WORD_W > WORD_W_MAX) begin : g_bad_width
        $error("Word width out of range");
    end
    if (TAP_COUNT < TAPS_MIN || TAP_COUNT > TAPS_MAX) begin : g_bad_taps
        $error("Tap count out of range");
    end
    if (SPACING < SPACING_MIN || SPACING > SPACING_MAX) begin : g_bad_space
        $error("Tap spacing out of range");
    end

    srtap_fifo_st_t                 fifo_st;
    logic [WORD_W-1:0]              head_word;
    logic                           en_eff;
    logic                           clr_async;
    logic                           advance;
    logic [TAP_COUNT:0][WORD_W-1:0] link;
    logic [TAP_COUNT-1:0][WORD_W-1:0] taps;
    srtap_state_t                   state_ff;
    srtap_state_t                   nxt_state;
    logic [FILL_CNT_W-1:0]          adv_cnt_ff;
    logic [FILL_CNT_W-1:0]          nxt_adv_cnt;
    logic                           primed_ff;
    logic                           nxt_primed;

    // Option gating: an absent port is ignored, an open enable reads high
    always_comb begin
        en_eff    = USE_CLKEN ? clk_en : 1'b1;
        clr_async = rst | (USE_ACLR & aclr);
        advance   = en_eff && fifo_st.not_empty;
    end

    // Buffer absorbs words while the chain is held by the enable and stalls the source once full
    srtap_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (BUF_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wr_valid (in_valid),
        .wr_data  (shift_in),
        .rd_ready (en_eff),
        .status   (fifo_st),
        .rd_data  (head_word)
    );

    assign in_ready = fifo_st.not_full;
    assign link[0]  = head_word;

    // Each segment forwards its outgoing word so taps stay exact multiples
    for (genvar k = 0; k < TAP_COUNT; k++) begin : g_seg
        srtap_seg #(
            .WORD_W  (WORD_W),
            .SPACING (SPACING)
        ) u_seg (
            .clk_sys  (clk_sys),
            .clr      (clr_async),
            .advance  (advance),
            .in_word  (link[k]),
            .rd_word  (link[k+1]),
            .tap_word (taps[k])
        );
        assign tap_bus[k*WORD_W +: WORD_W] = taps[k];
        assign tap_group[k] = GROUP_TAPS ? taps[k] : '0;
    end

    // Chain end is the last tap register, so a clear zeroes it at once
    assign shift_out = taps[TAP_COUNT-1];

    // Track how far the chain has filled since the last clear
    always_comb begin
        nxt_state   = state_ff;
        nxt_adv_cnt = adv_cnt_ff;
        unique case (state_ff)
            SRTAP_EMPTY: begin
                if (advance) begin
                    nxt_adv_cnt = FILL_CNT_W'(1);
                    nxt_state   = (CHAIN_LEN == 1) ? SRTAP_PRIMED : SRTAP_FILL;
                end
            end
            SRTAP_FILL: begin
                if (advance) begin
                    nxt_adv_cnt = adv_cnt_ff + FILL_CNT_W'(1);
                    if (adv_cnt_ff == FILL_CNT_W'(CHAIN_LEN - 1)) begin
                        nxt_state = SRTAP_PRIMED;
                    end
                end
            end
            SRTAP_PRIMED: begin
                nxt_adv_cnt = adv_cnt_ff;
            end
            default: begin
                nxt_state   = SRTAP_EMPTY;
                nxt_adv_cnt = '0;
            end
        endcase
        nxt_primed = (nxt_state == SRTAP_PRIMED);
    end

    always_ff @(posedge clk_sys or posedge clr_async) begin
        if (clr_async) begin
            state_ff   <= SRTAP_EMPTY;
            adv_cnt_ff <= '0;
            primed_ff  <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            adv_cnt_ff <= nxt_adv_cnt;
            primed_ff  <= nxt_primed;
        end
    end

    assign chain_primed = primed_ff;

    // One enabled step, then the first segment's outgoing word must show up in the first tap
    sequence adv_step_s;
        advance ##1 !clr_async;
    endsequence

    hold_idle_a: assert property (@(posedge clk_sys) disable iff (clr_async)
        !advance |=> $stable(tap_bus))
        else $error("Taps moved without an advance");
    clken_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        (USE_CLKEN && !clk_en) |-> !advance)
        else $error("Chain advanced with enable low");
    open_en_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!USE_CLKEN && fifo_st.not_empty) |-> advance)
        else $error("Chain stalled with no enable option");
    clear_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        (USE_ACLR && aclr) |-> shift_out == '0)
        else $error("Chain end not cleared");
    no_aclr_a: assert property (@(posedge clk_sys) disable iff (rst)
        (!USE_ACLR && aclr && !advance) |=> $stable(shift_out))
        else $error("Clear acted without the option");
    end_word_a: assert property (@(posedge clk_sys)
        shift_out == tap_bus[WORD_W*TAP_COUNT-1 -: WORD_W])
        else $error("Chain end differs from last stage");
    group_tap_a: assert property (@(posedge clk_sys)
        tap_group[0] == (GROUP_TAPS ? tap_bus[WORD_W-1:0] : '0))
        else $error("Tap group mismatch");
    primed_cnt_a: assert property (@(posedge clk_sys) disable iff (clr_async)
        (advance && state_ff == SRTAP_FILL
         && adv_cnt_ff == FILL_CNT_W'(CHAIN_LEN - 1)) |=> chain_primed)
        else $error("Primed flag late");
    first_stage_a: assert property (@(posedge clk_sys) disable iff (clr_async)
        adv_step_s |-> $past(link[1]) == taps[0])
        else $error("First tap did not step");
endmodule

// File: design/srtap_pkg.sv
// Constants and carrier types for the RAM-tapped shift register.
// Assumes one clock domain; every consumer imports the whole package.
package srtap_pkg;

    // Legal build ranges
    localparam int WORD_W_MIN   = 1;
    localparam int WORD_W_MAX   = 256;
    localparam int TAPS_MIN     = 1;
    localparam int TAPS_MAX     = 128;
    localparam int SPACING_MIN  = 3;
    localparam int SPACING_MAX  = 128;

    // Build defaults
    localparam int WORD_W_DEF   = 8;
    localparam int TAPS_DEF     = 4;
    localparam int SPACING_DEF  = 3;
    localparam int FIFO_DEPTH   = 16;

    // Advance counter must reach TAPS_MAX * SPACING_MAX
    localparam int FILL_CNT_W   = 15;

    // Chain fill progress, Gray along empty -> filling -> primed
    typedef enum logic [1:0] {
        SRTAP_EMPTY  = 2'h0,
        SRTAP_FILL   = 2'h1,
        SRTAP_PRIMED = 2'h3
    } srtap_state_t;

    // Handshake status of the input buffer
    typedef struct packed {
        logic not_full;
        logic not_empty;
    } srtap_fifo_st_t;

endpackage

// File: design/srtap_fifo.sv
// Synchronous FIFO in front of the shift chain.
// Assumes a single clock; pops only when the drain side is ready.
`timescale 1ns/10ps
module srtap_fifo
    import srtap_pkg::*;
#(
    parameter int WIDTH = WORD_W_DEF,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             wr_valid,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_ready,
    output srtap_fifo_st_t        status,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [CNT_W-1:0] count_ff;
    srtap_fifo_st_t   status_ff;
    logic [PTR_W-1:0] nxt_wr_ptr;
    logic [PTR_W-1:0] nxt_rd_ptr;
    logic [CNT_W-1:0] nxt_count;
    srtap_fifo_st_t   nxt_status;
    logic             do_wr;
    logic             do_rd;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
    endfunction

    // Flags are registered so the ready seen by the source never glitches
    always_comb begin
        do_wr      = wr_valid && status_ff.not_full;
        do_rd      = rd_ready && status_ff.not_empty;
        nxt_wr_ptr = do_wr ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
        nxt_rd_ptr = do_rd ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
        nxt_count  = count_ff;
        if (do_wr && !do_rd) begin
            nxt_count = count_ff + CNT_W'(1);
        end else if (do_rd && !do_wr) begin
            nxt_count = count_ff - CNT_W'(1);
        end
        nxt_status.not_full  = (nxt_count != CNT_W'(DEPTH));
        nxt_status.not_empty = (nxt_count != '0);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
            status_ff <= '{not_full: 1'b1, not_empty: 1'b0};
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff  <= nxt_count;
            status_ff <= nxt_status;
        end
    end

    // Storage is not reset; only pointers define what is valid
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr_ff] <= wr_data;
        end
    end

    assign rd_data = mem[rd_ptr_ff];
    assign status  = status_ff;

    full_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        !status_ff.not_full |-> count_ff == CNT_W'(DEPTH))
        else $error("Full flag without full count");
    empty_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        !status_ff.not_empty |-> count_ff == '0)
        else $error("Empty flag with stored words");
endmodule

// File: design/srtap_seg.sv
// One tap segment: a circular memory of SPACING words and a tap register.
// Assumes advance comes from the same clock; clr is an asynchronous clear.
`timescale 1ns/10ps
module srtap_seg
    import srtap_pkg::*;
#(
    parameter int WORD_W  = WORD_W_DEF,
    parameter int SPACING = SPACING_DEF
) (
    input  wire logic              clk_sys,
    input  wire logic              clr,
    input  wire logic              advance,
    input  wire logic [WORD_W-1:0] in_word,
    output logic      [WORD_W-1:0] rd_word,
    output logic      [WORD_W-1:0] tap_word
);
    localparam int PTR_W  = $clog2(SPACING);
    localparam int FILL_W = $clog2(SPACING + 1);

    logic [WORD_W-1:0] mem [SPACING];
    logic [PTR_W-1:0]  ptr_ff;
    logic [FILL_W-1:0] fill_ff;
    logic [WORD_W-1:0] tap_ff;
    logic [PTR_W-1:0]  nxt_ptr;
    logic [FILL_W-1:0] nxt_fill;
    logic [WORD_W-1:0] nxt_tap;
    logic              full;

    // Memory cannot be cleared at once, so unfilled slots read as zero
    always_comb begin
        full     = (fill_ff == FILL_W'(SPACING));
        rd_word  = full ? mem[ptr_ff] : '0;
        nxt_ptr  = ptr_ff;
        nxt_fill = fill_ff;
        nxt_tap  = tap_ff;
        if (advance) begin
            nxt_ptr  = (ptr_ff == PTR_W'(SPACING - 1)) ? '0 : ptr_ff + PTR_W'(1);
            nxt_fill = full ? fill_ff : fill_ff + FILL_W'(1);
            nxt_tap  = rd_word;
        end
    end

    always_ff @(posedge clk_sys or posedge clr) begin
        if (clr) begin
            ptr_ff  <= '0;
            fill_ff <= '0;
            tap_ff  <= '0;
        end else begin
            ptr_ff  <= nxt_ptr;
            fill_ff <= nxt_fill;
            tap_ff  <= nxt_tap;
        end
    end

    // Write the oldest slot as it is read out
    always_ff @(posedge clk_sys) begin
        if (advance) begin
            mem[ptr_ff] <= in_word;
        end
    end

    assign tap_word = tap_ff;

    seg_delay_a: assert property (@(posedge clk_sys) disable iff (clr)
        advance && full |=> tap_ff == $past(mem[ptr_ff]))
        else $error("Tap did not take oldest word");
    seg_unfilled_a: assert property (@(posedge clk_sys) disable iff (clr)
        advance && !full |=> tap_ff == '0)
        else $error("Unfilled slot leaked data");
endmodule

// File: verif/srtap_src.sv
// Source model of the user logic that feeds the shift register.
// Assumes one clock; sends words 1, 2, 3 ... and holds each one until taken.
`timescale 1ns/10ps
module srtap_src
    import srtap_pkg::*;
#(
    parameter int WORD_W = WORD_W_DEF
) (
    input  wire logic              clk_sys,
    input  wire logic              in_ready,
    output logic                   in_valid,
    output logic      [WORD_W-1:0] shift_in
);
    logic [WORD_W-1:0] next_val = WORD_W'(1);
    int                pending  = 0;
    logic              slow     = 1'b0;
    logic              gap      = 1'b0;

    task automatic send(input int n);
        pending = pending + n;
    endtask

    // Drive after the falling edge; an idle line shows a changing pattern, not stale data
    always @(negedge clk_sys) begin
        if (pending > 0 && !gap) begin
            in_valid <= 1'b1;
            shift_in <= next_val;
        end else begin
            in_valid <= 1'b0;
            shift_in <= ~shift_in;
        end
        gap <= 1'b0;
    end

    // A word counts as taken only at a rising edge that sees ready high
    always @(posedge clk_sys) begin
        if (in_valid && in_ready) begin
            next_val <= next_val + 1'b1;
            pending  <= pending - 1;
            gap      <= slow;
        end
    end

    initial begin
        in_valid = 1'b0;
        shift_in = '0;
    end
endmodule

// File: verif/testbench.sv
// Self-checking bench: a fully optioned instance and one with all options off.
// Assumes the source model feeds both; the second only sees words the first took.
`timescale 1ns/10ps
module testbench;
    import srtap_pkg::*;
    localparam int W = 8;
    localparam int T = 4;
    localparam int S = 3;
    typedef struct {int n; logic [W*T-1:0] bus; logic primed;} srtap_row_t;

    logic                clk_sys = 1'b0;
    logic                rst     = 1'b1;
    logic                clk_en  = 1'b1;
    logic                aclr    = 1'b0;
    logic                in_valid, in_ready, vld_b, primed, primed_b;
    logic [W-1:0]        shift_in, shift_out, out_b;
    logic [W*T-1:0]      tap_bus, bus_b;
    logic [T-1:0][W-1:0] tap_group, grp_b;
    int                  err_count   = 0;
    int                  checks_done = 0;
    // Words sent by each push, with the taps expected once the running total drains
    srtap_row_t rows[6] = '{'{1, 32'h00000000, 1'b0}, '{3, 32'h00000001, 1'b0},
                            '{4, 32'h00000205, 1'b0}, '{3, 32'h00020508, 1'b0},
                            '{1, 32'h00030609, 1'b1}, '{3, 32'h0306090c, 1'b1}};

    always #4 clk_sys = ~clk_sys;
    // Second copy only takes words the first accepted, so both see one stream
    assign vld_b = in_valid & in_ready;

    srtap_src #(.WORD_W(W)) srtap_src_inst (.clk_sys(clk_sys), .in_ready(in_ready),
        .in_valid(in_valid), .shift_in(shift_in));

    srtap_top #(.WORD_W(W), .TAP_COUNT(T), .SPACING(S), .USE_CLKEN(1'b1), .USE_ACLR(1'b1),
        .GROUP_TAPS(1'b1)) srtap_top_inst (.clk_sys(clk_sys), .rst(rst),
        .clk_en(clk_en), .aclr(aclr), .in_valid(in_valid), .shift_in(shift_in),
        .in_ready(in_ready), .tap_bus(tap_bus), .tap_group(tap_group),
        .shift_out(shift_out), .chain_primed(primed));

    // Options left at their defaults, so enable and clear reach ports that must be ignored
    srtap_top #(.WORD_W(W), .TAP_COUNT(T), .SPACING(S)) srtap_top_inst_b (.clk_sys(clk_sys),
        .rst(rst),
        .clk_en(clk_en), .aclr(aclr), .in_valid(vld_b), .shift_in(shift_in),
        .in_ready(), .tap_bus(bus_b), .tap_group(grp_b), .shift_out(out_b),
        .chain_primed(primed_b));

    task automatic cmp_bus(input logic [W*T-1:0] got, input logic [W*T-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_bus({{(W*T-1){1'b0}}, got}, {{(W*T-1){1'b0}}, exp});
    endtask

    // Bounded wait for the source, then time for the buffer to drain into the chain
    task automatic push(input int n);
        srtap_src_inst.send(n);
        for (int i = 0; i < 400 && srtap_src_inst.pending > 0; i++) @(negedge clk_sys);
        repeat (24) @(negedge clk_sys);
    endtask

    task automatic conclude();
        if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #40000;
        err_count++;
        conclude();
    end

    initial begin
        repeat (4) @(negedge clk_sys);
        cmp_bit(in_ready, 1'b1);
        cmp_bus(tap_bus, '0);
        cmp_bit(primed, 1'b0);
        @(negedge clk_sys);
        rst = 1'b0;
        foreach (rows[i]) begin
            push(rows[i].n);
            cmp_bus(tap_bus, rows[i].bus);
            cmp_bus(tap_group, rows[i].bus);
            cmp_bus(32'(shift_out), 32'(rows[i].bus[W*T-1 -: W]));
            cmp_bit(primed, rows[i].primed);
            cmp_bus(bus_b, rows[i].bus);
            cmp_bus(grp_b, '0);
            cmp_bus(32'(out_b), 32'(rows[i].bus[W*T-1 -: W]));
            cmp_bit(primed_b, rows[i].primed);
        end
        // Enable low: buffer fills to 16 and refuses, main chain frozen
        clk_en = 1'b0;
        srtap_src_inst.send(17);
        repeat (30) @(negedge clk_sys);
        cmp_bit(in_ready, 1'b0);
        cmp_bus(tap_bus, 32'h0306090c);
        cmp_bus(bus_b, 32'h1316191c);
        clk_en = 1'b1;
        push(0);
        cmp_bus(tap_bus, 32'h14171a1d);
        cmp_bus(bus_b, 32'h14171a1d);
        // Clear at the falling edge, half a cycle from the rising one, and look before it
        aclr = 1'b1;
        #1;
        cmp_bus(32'(shift_out), '0);
        cmp_bus(tap_bus, '0);
        cmp_bit(primed, 1'b0);
        cmp_bus(bus_b, 32'h14171a1d);
        @(negedge clk_sys);
        aclr = 1'b0;
        // Refill slowly after the clear: old words must not reappear
        srtap_src_inst.slow = 1'b1;
        push(12);
        cmp_bus(tap_bus, 32'h00232629);
        cmp_bit(primed, 1'b1);
        cmp_bus(bus_b, 32'h20232629);
        conclude();
    end
endmodule
